// *** src/wtes_pkg.sv ***
package wtes_pkg;

    // Widths
    localparam int unsigned DATA_W   = 12;
    localparam int unsigned REG_W    = 8;
    localparam int unsigned NUM_AXES = 3;
    localparam int unsigned IDX_W    = 8;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS   = 8'h2E;
    localparam logic [7:0] IDX_CFG_A    = 8'h2F;
    localparam logic [7:0] IDX_UPPER    = 8'h30;
    localparam logic [7:0] IDX_LOWER    = 8'h31;
    localparam logic [7:0] IDX_DBCNT    = 8'h32;
    localparam logic [7:0] IDX_CFG_B    = 8'h33;
    localparam logic [7:0] IDX_WAKE     = 8'h34;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h35;
    localparam logic [7:0] IDX_IRQ_CLR  = 8'h36;
    localparam logic [7:0] IDX_IRQ_EN   = 8'h37;

    // Field positions; axis i lands in status bit 2*i+1
    localparam int unsigned STAT_ACTIVE_BIT = 7;
    localparam int unsigned CFG_A_LATCH_BIT = 6;
    localparam int unsigned CFG_B_ALL_BIT   = 0;
    localparam int unsigned CFG_B_PIN_BIT   = 1;
    localparam int unsigned WAKE_HOLD_BIT   = 0;
    localparam int unsigned IRQ_RISE_BIT    = 0;
    localparam int unsigned IRQ_FALL_BIT    = 1;
    localparam int unsigned IRQ_W           = 2;

    // Reset values, the OKAY response code and the debounce count limit
    localparam logic [7:0]  RST_REG8  = 8'h00;
    localparam logic [11:0] RST_THR   = 12'h000;
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [1:0]  HRESP_OK  = 2'h0;
    localparam logic [7:0]  DBCNT_MAX = 8'hFF;

endpackage : wtes_pkg

// *** src/wtes_eval_if.sv ***
// Window evaluation and debounce signals shared with the control block
interface wtes_eval_if;
    logic [2:0][11:0] axis_val;
    logic [11:0]      upper;
    logic [11:0]      lower;
    logic [2:0]       axis_en;
    logic             combine_all;
    logic [2:0]       in_win;
    logic             cond;
    logic             odr_tick;
    logic             latch_en;
    logic             rd_clear;
    logic [7:0]       dbcnt;
    logic             active;
    logic             reached;
    logic             updated;

    modport eval (input axis_val, upper, lower, axis_en, combine_all,
                  output in_win, cond);
    modport deb  (input cond, odr_tick, latch_en, rd_clear, dbcnt,
                  output active, reached, updated);
    modport ctl  (output axis_val, upper, lower, axis_en, combine_all,
                  odr_tick, latch_en, rd_clear, dbcnt,
                  input in_win, cond, active, reached, updated);
endinterface : wtes_eval_if

// *** src/wtes_window_eval.sv ***
module wtes_window_eval (
    wtes_eval_if.eval ev
);
    // Per-axis strict window compare, signed values
    for (genvar i = 0; i < 3; i++) begin : g_axis
        assign ev.in_win[i] =
            ($signed(ev.axis_val[i]) > $signed(ev.lower)) &&
            ($signed(ev.axis_val[i]) < $signed(ev.upper));
    end

    // Disabled axes count as passing for AND, failing for OR
    assign ev.cond = (|ev.axis_en) &&
        (ev.combine_all ? &(ev.in_win | ~ev.axis_en)
                        : |(ev.in_win & ev.axis_en));
endmodule // wtes_window_eval

// *** src/wtes_debounce.sv ***
module wtes_debounce (
    input  wire logic ref_clk,
    input  wire logic resetn,
    wtes_eval_if.deb  db
);
    typedef enum logic [0:0] {
        ST_ARMED = 1'b0,
        ST_FIRED = 1'b1
    } wtes_deb_e;

    typedef struct packed {
        wtes_deb_e  st;
        logic [7:0] cnt;
        logic       active;
        logic       reached;
        logic       updated;
    } wtes_deb_s;

    wtes_deb_s q;
    wtes_deb_s next_q;
    logic [7:0] cnt_new;

    // Count qualifying OUTPUT_DATA_RATE cycles, saturating, restart on a miss
    always_comb begin
        next_q = q;
        next_q.updated = db.odr_tick;
        cnt_new = db.cond ? ((q.cnt == wtes_pkg::DBCNT_MAX) ? q.cnt
                             : q.cnt + 8'h01) : 8'h00;
        if (db.odr_tick) begin
            next_q.cnt = cnt_new;
            next_q.reached = db.cond && (cnt_new >= db.dbcnt);
        end
        if (!db.latch_en) begin
            // Real time: follows the debounced condition
            next_q.st = ST_ARMED;
            if (db.odr_tick) begin
                next_q.active = db.cond && (cnt_new >= db.dbcnt);
            end
        end else begin
            // Sticky until status read; rearm once condition drops
            if (db.rd_clear) begin
                next_q.active = 1'b0;
            end
            unique case (q.st)
                ST_ARMED: begin
                    if (db.odr_tick && db.cond &&
                        cnt_new >= db.dbcnt) begin
                        next_q.active = 1'b1;
                        next_q.st = ST_FIRED;
                    end
                end
                ST_FIRED: begin
                    if (db.odr_tick && !db.cond) begin
                        next_q.st = ST_ARMED;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            q <= '{ST_ARMED, wtes_pkg::RST_REG8, 1'b0, 1'b0, 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign db.active  = q.active;
    assign db.reached = q.reached;
    assign db.updated = q.updated;
endmodule // wtes_debounce

// *** src/wtes_top.sv ***
// Added by the designer: the AHB-Lite interface to the registers.
module wtes_top (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Sample stream from the data path, same clock
    input  wire logic        odr_tick,
    input  wire logic [11:0] x_value,
    input  wire logic [11:0] y_value,
    input  wire logic [11:0] z_value,
    // Event signalling
    output logic             interrupt_pin_one,
    output logic             interrupt_pin_two,
    output logic             irq,
    output logic             sleep_hold,
    output logic             wake_timer_reset
);

    // All control and status state of the block except the debouncer's
    typedef struct packed {
        logic [11:0] upper_threshold;
        logic [11:0] lower_threshold;
        logic [7:0]  window_debounce_count;
        logic [7:0]  change_detect_config_a;
        logic [7:0]  change_detect_config_b;
        logic [7:0]  sensor_wake_config;
        logic [2:0]  axis_flags;
        logic        prev_active;
        logic [1:0]  irq_status;
        logic [1:0]  irq_enable;
        logic        dp_write;
        logic        dp_valid;
        logic [7:0]  dp_index;
        logic [31:0] rdata;
    } wtes_state_s;

    wtes_state_s q;
    wtes_state_s next_q;

    wtes_eval_if ev ();

    // Address decode: word aligned and within the small map
    function automatic logic [8:0] decode_index(input logic [31:0] addr);
        logic ok;
        ok = (addr[31:10] == 22'h00_0000) && (addr[1:0] == 2'b00);
        return {ok, addr[9:2]};
    endfunction

    // Status byte as seen by software
    function automatic logic [7:0] status_byte(input logic       act,
                                               input logic [2:0] fl);
        logic [7:0] v;
        v = wtes_pkg::RST_REG8;
        v[wtes_pkg::STAT_ACTIVE_BIT] = act;
        for (int i = 0; i < 3; i++) begin
            v[2 * i + 1] = fl[i];
        end
        return v;
    endfunction

    logic        accept;
    logic [8:0]  a_dec;
    logic        rd_status;
    logic [7:0]  rd_byte;
    logic        act_rise;
    logic        act_fall;
    logic        rt_update;
    logic [2:0]  en_bits;
    logic        latch_mode;

    // Address phase is taken when selected, ready and NONSEQ or SEQ
    assign accept    = hsel && hready && htrans[1];
    assign a_dec     = decode_index(haddr);
    // A read of the status word clears latched state
    assign rd_status = accept && !hwrite && a_dec[8] &&
                       (a_dec[7:0] == wtes_pkg::IDX_STATUS);

    assign en_bits    = q.change_detect_config_a[2:0];
    assign latch_mode =
        q.change_detect_config_a[wtes_pkg::CFG_A_LATCH_BIT];

    // Feed the evaluator and debouncer; X is axis 2, Z axis 0
    assign ev.axis_val    = {x_value, y_value, z_value};
    assign ev.upper       = q.upper_threshold;
    assign ev.lower       = q.lower_threshold;
    assign ev.axis_en     = en_bits;
    assign ev.combine_all =
        q.change_detect_config_b[wtes_pkg::CFG_B_ALL_BIT];
    assign ev.odr_tick    = odr_tick;
    assign ev.latch_en    = latch_mode;
    assign ev.rd_clear    = rd_status;
    assign ev.dbcnt       = q.window_debounce_count;

    wtes_window_eval u_eval (
        .ev (ev.eval)
    );

    wtes_debounce u_deb (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .db      (ev.deb)
    );

    // Edges of the active flag drive capture and interrupts
    assign act_rise = ev.active && !q.prev_active;
    assign act_fall = !ev.active && q.prev_active;

    // Real-time refresh happens the cycle after a sample tick that reached the debounce count, or after any tick when the count is zero,
    // once the debouncer has settled on that sample
    assign rt_update = ev.updated &&
        ((ev.active && ev.reached) ||
         (q.window_debounce_count == wtes_pkg::RST_REG8));

    // Read data mux; unmapped and write-only words read zero
    always_comb begin
        rd_byte = wtes_pkg::RST_REG8;
        if (a_dec[8]) begin
            unique case (a_dec[7:0])
                wtes_pkg::IDX_STATUS:
                    rd_byte = status_byte(ev.active, q.axis_flags);
                wtes_pkg::IDX_CFG_A:   rd_byte = q.change_detect_config_a;
                wtes_pkg::IDX_DBCNT:   rd_byte = q.window_debounce_count;
                wtes_pkg::IDX_CFG_B:   rd_byte = q.change_detect_config_b;
                wtes_pkg::IDX_WAKE:    rd_byte = q.sensor_wake_config;
                wtes_pkg::IDX_IRQ_STAT:
                    rd_byte = {6'h00, q.irq_status};
                wtes_pkg::IDX_IRQ_EN:  rd_byte = {6'h00, q.irq_enable};
                default:               rd_byte = wtes_pkg::RST_REG8;
            endcase
        end
    end

    // Next state: bus phases, register writes, flags and interrupts
    always_comb begin
        next_q = q;
        next_q.prev_active = ev.active;

        // Address phase: remember the write, capture read data now
        next_q.dp_write = accept && hwrite;
        next_q.dp_valid = a_dec[8];
        next_q.dp_index = a_dec[7:0];
        if (accept && !hwrite) begin
            next_q.rdata = {24'h00_0000, rd_byte};
            // Thresholds are wider than a byte, read separately
            if (a_dec[8] && a_dec[7:0] == wtes_pkg::IDX_UPPER) begin
                next_q.rdata = {20'h0_0000, q.upper_threshold};
            end
            if (a_dec[8] && a_dec[7:0] == wtes_pkg::IDX_LOWER) begin
                next_q.rdata = {20'h0_0000, q.lower_threshold};
            end
        end

        // Data phase write; status word ignores writes
        if (q.dp_write && q.dp_valid) begin
            unique case (q.dp_index)
                wtes_pkg::IDX_CFG_A:
                    next_q.change_detect_config_a = hwdata[7:0];
                wtes_pkg::IDX_UPPER:
                    next_q.upper_threshold = hwdata[11:0];
                wtes_pkg::IDX_LOWER:
                    next_q.lower_threshold = hwdata[11:0];
                wtes_pkg::IDX_DBCNT:
                    next_q.window_debounce_count = hwdata[7:0];
                wtes_pkg::IDX_CFG_B:
                    next_q.change_detect_config_b = hwdata[7:0];
                wtes_pkg::IDX_WAKE:
                    next_q.sensor_wake_config = hwdata[7:0];
                wtes_pkg::IDX_IRQ_CLR:
                    next_q.irq_status = q.irq_status & ~hwdata[1:0];
                wtes_pkg::IDX_IRQ_EN:
                    next_q.irq_enable = hwdata[1:0];
                default: ;
            endcase
        end

        // Axis flags: sticky capture or real-time follow
        if (latch_mode) begin
            // Read clears first so a same-cycle capture wins
            if (rd_status) begin
                next_q.axis_flags = 3'b000;
            end
            if (act_rise) begin
                next_q.axis_flags =
                    next_q.axis_flags | (ev.in_win & en_bits);
            end
        end else if (rt_update) begin
            next_q.axis_flags = ev.in_win & en_bits;
        end

        // Sticky interrupt sources; a new event beats the clear
        if (act_rise) begin
            next_q.irq_status[wtes_pkg::IRQ_RISE_BIT] = 1'b1;
        end
        if (act_fall) begin
            next_q.irq_status[wtes_pkg::IRQ_FALL_BIT] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            q.upper_threshold        <= wtes_pkg::RST_THR;
            q.lower_threshold        <= wtes_pkg::RST_THR;
            q.window_debounce_count  <= wtes_pkg::RST_REG8;
            q.change_detect_config_a <= wtes_pkg::RST_REG8;
            q.change_detect_config_b <= wtes_pkg::RST_REG8;
            q.sensor_wake_config     <= wtes_pkg::RST_REG8;
            q.axis_flags             <= 3'b000;
            q.prev_active            <= 1'b0;
            q.irq_status             <= 2'b00;
            q.irq_enable             <= 2'b00;
            q.dp_write               <= 1'b0;
            q.dp_valid               <= 1'b0;
            q.dp_index               <= wtes_pkg::RST_REG8;
            q.rdata                  <= wtes_pkg::RST_WORD;
        end else begin
            q <= next_q;
        end
    end

    // Zero-wait slave, always OKAY; sizes are not checked
    assign hreadyout = 1'b1;
    assign hresp     = wtes_pkg::HRESP_OK[0];
    assign hrdata    = q.rdata;

    // Active flag routed to one pin, the other held low
    assign interrupt_pin_one = ev.active &&
        !q.change_detect_config_b[wtes_pkg::CFG_B_PIN_BIT];
    assign interrupt_pin_two = ev.active &&
        q.change_detect_config_b[wtes_pkg::CFG_B_PIN_BIT];

    // Level interrupt from enabled sticky sources
    assign irq = |(q.irq_status & q.irq_enable);

    // Sleep is blocked for as long as the flag stays up
    assign sleep_hold = ev.active &&
        q.sensor_wake_config[wtes_pkg::WAKE_HOLD_BIT];
    assign wake_timer_reset = sleep_hold && ev.updated;

endmodule // wtes_top

// *** test/wtes_chk.sv ***
module wtes_chk (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        odr_tick,
    input wire logic        interrupt_pin_one,
    input wire logic        interrupt_pin_two,
    input wire logic        sleep_hold,
    input wire logic        wake_timer_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    // Read accept terms; route may move the event between pins
    logic pin_any;
    logic rd_acc;
    logic st_acc;
    assign pin_any = interrupt_pin_one | interrupt_pin_two;
    assign rd_acc = hsel & hready & htrans[1] & ~hwrite;
    assign st_acc = rd_acc & (haddr == 32'h0000_00B8);

    property p_okay;
        hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("bus not okay");
    property p_rise_tick;
        $rose(pin_any) |-> $past(odr_tick);
    endproperty
    a_rise_tick: assert property (p_rise_tick) else $error("rise off tick");
    property p_sleep_pin;
        sleep_hold |-> pin_any;
    endproperty
    a_sleep_pin: assert property (p_sleep_pin) else $error("hold idle");
    property p_wake_after;
        odr_tick ##1 sleep_hold |-> wake_timer_reset;
    endproperty
    a_wake_after: assert property (p_wake_after) else $error("no wake");
    property p_wake_cause;
        wake_timer_reset |-> $past(odr_tick) && !$past(wake_timer_reset);
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("odd wake");
    property p_st_resv;
        st_acc |=> (hrdata & 32'hFFFF_FF55) == 32'h0000_0000;
    endproperty
    a_st_resv: assert property (p_st_resv) else $error("resv bit set");
    property p_st_active;
        st_acc |-> ##1 hrdata[7] == $past(pin_any);
    endproperty
    a_st_active: assert property (p_st_active) else $error("bit7 off");
    property p_rd_stands;
        !rd_acc |=> $stable(hrdata);
    endproperty
    a_rd_stands: assert property (p_rd_stands) else $error("hrdata moved");
endmodule // wtes_chk

bind wtes_top wtes_chk wtes_chk_inst (
    .ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .odr_tick, .interrupt_pin_one,
    .interrupt_pin_two, .sleep_hold, .wake_timer_reset
);

// *** test/wtes_host.sv ***
module wtes_host (
    input  wire logic        ref_clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    output logic             rd_valid,
    output logic [31:0]      rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idle from time zero so reset sees no request
    initial begin
        {hsel, hwrite, rd_valid, htrans} = '0;
        {haddr, hsize, hwdata, rd_data} = '0;
    end

    // One word transfer; never assumes the zero-wait answer
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        rd_valid <= 1'b0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        if (!wr) begin
            rd_data <= hrdata;
            rd_valid <= 1'b1;
        end
    endtask
endmodule // wtes_host

// *** test/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, resetn, hsel, hwrite, hready, hresp, odr_tick;
    logic        irq, sleep_hold, wake_timer_reset, rd_valid;
    logic        interrupt_pin_one, interrupt_pin_two;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [11:0] x_value, y_value, z_value;
    logic [31:0] haddr, hwdata, hrdata, rd_data;
    logic [31:0] exp_q[$];
    int          miscompares, n_checks, cyc;
    localparam logic [11:0] thr_hi = 12'h100;
    localparam logic [11:0] thr_lo = 12'hF00;

    wtes_top wtes_top_inst (
        .ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .odr_tick,
        .x_value, .y_value, .z_value, .interrupt_pin_one,
        .interrupt_pin_two, .irq, .sleep_hold, .wake_timer_reset
    );
    wtes_host wtes_host_inst (
        .ref_clk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .rd_valid, .rd_data
    );

    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Each finished read retires the oldest expected word
    always @(posedge rd_valid) begin
        chk(rd_data, exp_q.pop_front());
    end

    // Hang guard: the run needs about 130 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            miscompares++;
            test_done();
        end
    end

    function automatic logic [31:0] ad(input logic [7:0] i);
        return {22'h00_0000, i, 2'b00};
    endfunction

    // Random sample strictly inside the window
    function automatic logic [11:0] rin();
        return 12'($urandom_range(510)) - 12'h0FF;
    endfunction

    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        wtes_host_inst.xfer(1'b1, ad(i), d);
    endtask

    task automatic rd(input logic [7:0] i, input logic [31:0] e);
        exp_q.push_back(e);
        wtes_host_inst.xfer(1'b0, ad(i), 32'h0000_0000);
    endtask

    // Flags land one edge after the tick, so wait two edges
    task automatic tick(input logic [11:0] x, input logic [11:0] y,
                        input logic [11:0] z);
        x_value <= x;
        y_value <= y;
        z_value <= z;
        odr_tick <= 1'b1;
        @(posedge ref_clk);
        odr_tick <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    // Levels as {irq, pin two, pin one, sleep hold}
    task automatic pins(input logic [3:0] e);
        @(posedge ref_clk);
        chk({28'h000_0000, irq, interrupt_pin_two, interrupt_pin_one,
             sleep_hold}, {28'h000_0000, e});
    endtask

    // Main sequence
    initial begin
        {resetn, odr_tick, x_value, y_value, z_value} = '0;
        void'($urandom(51922));
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rd(wtes_pkg::IDX_STATUS, 32'h0000_0000);
        wr(wtes_pkg::IDX_STATUS, 32'h0000_00FF);
        rd(wtes_pkg::IDX_STATUS, 32'h0000_0000);
        rd(8'h10, 32'h0000_0000);
        wr(wtes_pkg::IDX_UPPER, 32'h0000_0100);
        wr(wtes_pkg::IDX_LOWER, 32'h0000_0F00);
        rd(wtes_pkg::IDX_LOWER, 32'h0000_0F00);
        wr(wtes_pkg::IDX_IRQ_EN, 32'h0000_0001);
        wr(wtes_pkg::IDX_CFG_A, 32'h0000_0007);
        // Any-axis mode; Y on the upper and Z on the lower edge
        tick(rin(), thr_hi, thr_lo);
        pins(4'b1010);
        rd(wtes_pkg::IDX_STATUS, 32'h0000_00A0);
        // All-axes mode fails, yet zero debounce still moves the flags
        wr(wtes_pkg::IDX_CFG_B, 32'h0000_0001);
        tick(rin(), rin(), thr_hi);
        rd(wtes_pkg::IDX_STATUS, 32'h0000_0028);
        rd(wtes_pkg::IDX_IRQ_STAT, 32'h0000_0003);
        wr(wtes_pkg::IDX_IRQ_EN, 32'h0000_0000);
        pins(4'b0000);
        wr(wtes_pkg::IDX_IRQ_CLR, 32'h0000_0003);
        wr(wtes_pkg::IDX_IRQ_EN, 32'h0000_0001);
        rd(wtes_pkg::IDX_IRQ_STAT, 32'h0000_0000);
        pins(4'b0000);
        // No axis enabled: the window is off
        wr(wtes_pkg::IDX_CFG_A, 32'h0000_0000);
        tick(rin(), rin(), rin());
        rd(wtes_pkg::IDX_STATUS, 32'h0000_0000);
        // Y alone counts; route to pin two and hold wake
        wr(wtes_pkg::IDX_CFG_A, 32'h0000_0002);
        tick(thr_hi, rin(), thr_lo);
        rd(wtes_pkg::IDX_STATUS, 32'h0000_0088);
        wr(wtes_pkg::IDX_CFG_B, 32'h0000_0003);
        wr(wtes_pkg::IDX_WAKE, 32'h0000_0001);
        pins(4'b1101);
        tick(thr_hi, rin(), thr_lo);
        wr(wtes_pkg::IDX_WAKE, 32'h0000_0000);
        wr(wtes_pkg::IDX_CFG_B, 32'h0000_0000);
        wr(wtes_pkg::IDX_CFG_A, 32'h0000_0007);
        // Debounce of three: two samples in the window are too few
        tick(thr_lo, thr_lo, thr_lo);
        wr(wtes_pkg::IDX_DBCNT, 32'h0000_0003);
        repeat (2) tick(rin(), rin(), rin());
        rd(wtes_pkg::IDX_STATUS, 32'h0000_0000);
        tick(rin(), rin(), rin());
        rd(wtes_pkg::IDX_STATUS, 32'h0000_00AA);
        // Latched: X leaves later but stays captured until read
        wr(wtes_pkg::IDX_DBCNT, 32'h0000_0000);
        tick(thr_lo, thr_lo, thr_lo);
        wr(wtes_pkg::IDX_CFG_A, 32'h0000_0047);
        tick(rin(), rin(), rin());
        tick(thr_hi, rin(), rin());
        rd(wtes_pkg::IDX_STATUS, 32'h0000_00AA);
        rd(wtes_pkg::IDX_STATUS, 32'h0000_0000);
        tick(rin(), rin(), rin());
        rd(wtes_pkg::IDX_STATUS, 32'h0000_0000);
        tick(thr_lo, thr_lo, thr_lo);
        tick(rin(), rin(), rin());
        rd(wtes_pkg::IDX_STATUS, 32'h0000_00AA);
        // Let the last read retire before judging the queue
        repeat (2) @(posedge ref_clk);
        chk(32'(exp_q.size()), 32'h0000_0000);
        test_done();
    end
endmodule // tb_top
